// *** include/scd_map.svh ***
// Register offsets, field positions, reset values and timing for the dial control block
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SCD_A_CTRL 8'h00
`define SCD_A_RETRY 8'h04
`define SCD_A_WAIT 8'h08
`define SCD_A_DELAY 8'h0c
`define SCD_A_MIND 8'h10
`define SCD_A_INACT 8'h14
`define SCD_A_NUMS 8'h18
`define SCD_A_ALLOW 8'h1c
`define SCD_A_STAT 8'h20
// ****************************************
// Field positions
// ****************************************
`define SCD_F_CFG 5:0
`define SCD_F_NNUM 9:8
`define SCD_F_NALW 11:10
// ****************************************
// Reset values (times in ms)
// ****************************************
`define SCD_R_RETRY 4'h3
`define SCD_R_WAIT 20'h07530
`define SCD_R_DELAY 20'h01388
`define SCD_R_MIND 20'h2bf20
`define SCD_R_INACT 20'h0ea60
// ****************************************
// Command codes on the serial dialog
// ****************************************
`define SCD_C_CRN 8'hc1
`define SCD_C_VAL 8'h56
`define SCD_C_INC 8'h49
`define SCD_C_CFI 8'h46
// ****************************************
// Timing
// ****************************************
`define SCD_CLK_NS 20
`define SCD_MS_NS 1000000
`define SCD_GUARD_MS 20'h003e8
`endif

// *** include/scd_pkg.sv ***
// Types shared by the dial control block
package scd_pkg;
	typedef struct packed {
		logic screen;
		logic pool;
		logic x21;
		logic v25;
		logic pend;
		logic en;
	} scd_cfg_t;
	typedef struct packed {
		logic rxd;
		logic dsr;
		logic cts;
		logic sclk;
	} scd_lnk_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CALL = 3'h1,
		S_SEND = 3'h3,
		S_WAIT = 3'h2,
		S_UP = 3'h6,
		S_FAIL = 3'h7,
		S_DROP = 3'h5,
		S_ANS = 3'h4
	} scd_st_t;
endpackage

// *** src/scd_dial.sv ***
// Switched circuit dial control: connection state machine, timers and dialog link
// Operation
// [RULE1] Manual adapter: connect by raising DTR, disconnect by dropping it.
// [RULE2] Manual port connects on circuit enable or only when data is pending.
// [RULE3] Data pending means a packet is held for the switched circuit.
// [RULE4] No ring indicator: manual port in pending mode never answers calls.
// [RULE5] One side pends, other enables; enable mode never drops, pend never calls. Pend mode here still calls when data is pending.
// [RULE6] Retry count, connect wait and post-failure delay are configurable.
// [RULE7] Close once no data moved either way for one inactivity period.
// [RULE8] Hold the circuit until one second before minimum connect duration.
// [RULE9] Adapter raises CTS when ready for a command dialog.
// [RULE10] Router sends a connection request carrying the number to dial.
// [RULE11] Adapter answers a valid request with VAL, meaning accepted only.
// [RULE12] Originating adapter drops CTS on answer tone, then places call.
// [RULE13] Answering adapter sends incoming indication plus caller number.
// [RULE14] Incoming call failing restrictions: drop DTR at once to reject.
// [RULE15] Circuit counts as established only once DSR is raised.
// [RULE16] V.25 bis operation is refused on X.21 ports.
// [RULE17] Pool member ports accept only pending-data-or-incoming-call mode.
// [RULE18] Screening accepts only listed caller numbers; needs caller number.
// [RULE19] When dialing a number fails, dial the next number.
// [RULE20] Pools reach at most 16 networks and hold at most three ports.
// [RULE21] After failure wait the delay, retry, give up when count exhausted.
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_dial
	import scd_pkg::*;
#(
	parameter int TICK_CYC = `SCD_MS_NS / `SCD_CLK_NS,
	parameter int POOL_PORTS = 3,
	parameter int POOL_NETS = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Router side
	input wire logic pkt_pend,
	input wire logic tx_act,
	input wire logic rx_act,
	// Adapter pins
	input wire scd_lnk_t lnk,
	output logic dtr,
	output logic txd
);
	if (POOL_PORTS < 1 || POOL_PORTS > 3
		|| POOL_NETS < 1 || POOL_NETS > 16) begin : g_bad_pool
		$error("pool size out of range"); // RULE20
	end
	if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_bad_tick
		$error("tick count out of range");
	end
	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic rq1_r, rsn;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rq1_r <= 1'b0;
			rsn <= 1'b0;
		end else begin
			rq1_r <= 1'b1;
			rsn <= rq1_r;
		end
	end
	logic [3:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
	// Change counts only once stages two and three agree
	for (genvar i = 0; i < 4; i++) begin : g_pin
		always_comb begin
			pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
		end
	end
	always_ff @(posedge clk or negedge rsn) begin
		if (!rsn) begin
			s1_r <= 4'h8;
			s2_r <= 4'h8;
			s3_r <= 4'h8;
			pin_r <= 4'h8;
		end else begin
			s1_r <= lnk;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= pin_nxt;
		end
	end
	scd_lnk_t p;
	assign p = pin_r;
	logic sc_rise, sc_fall;
	assign sc_rise = pin_nxt[0] & ~pin_r[0];
	assign sc_fall = ~pin_nxt[0] & pin_r[0];
	// ****************************************
	// Registers
	// ****************************************
	scd_cfg_t cfg_r, cfg_nxt;
	logic [3:0] retry_r, retry_nxt;
	logic [19:0] wait_r, wait_nxt, dly_r, dly_nxt;
	logic [19:0] mind_r, mind_nxt, inact_r, inact_nxt;
	logic [31:0] nums_r, nums_nxt, alw_r, alw_nxt, rdata_nxt;
	logic [1:0] nnum_r, nnum_nxt, nalw_r, nalw_nxt;
	scd_st_t st_r, st_nxt;
	logic [19:0] tmr_r, tmr_nxt, age_r, age_nxt, idle_r, idle_nxt;
	logic [3:0] tries_r, tries_nxt;
	logic [1:0] nidx_r, nidx_nxt;
	logic gup_r, gup_nxt, cfg_err, tick;
	logic [15:0] pre_r, pre_nxt;
	logic [16:0] tsh_r, tsh_nxt;
	logic [4:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
	logic [15:0] rsh_r, rsh_nxt;
	logic rvld, tx_go;
	function automatic logic listed(input logic [7:0] num, input logic [31:0] tbl,
		input logic [1:0] n);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 4; k++) begin
			if (k <= int'(n) && tbl[k*8 +: 8] == num) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction
	always_comb begin
		cfg_nxt = cfg_r;
		retry_nxt = retry_r;
		wait_nxt = wait_r;
		dly_nxt = dly_r;
		mind_nxt = mind_r;
		inact_nxt = inact_r;
		nums_nxt = nums_r;
		alw_nxt = alw_r;
		nnum_nxt = nnum_r;
		nalw_nxt = nalw_r;
		rdata_nxt = 32'h0;
		if (wr) begin
			if (addr == `SCD_A_CTRL) begin
				cfg_nxt = wdata[`SCD_F_CFG];
				nnum_nxt = wdata[`SCD_F_NNUM];
				nalw_nxt = wdata[`SCD_F_NALW];
			end else if (addr == `SCD_A_RETRY) begin
				retry_nxt = wdata[3:0];
			end else if (addr == `SCD_A_WAIT) begin
				wait_nxt = wdata[19:0];
			end else if (addr == `SCD_A_DELAY) begin
				dly_nxt = wdata[19:0];
			end else if (addr == `SCD_A_MIND) begin
				mind_nxt = wdata[19:0];
			end else if (addr == `SCD_A_INACT) begin
				inact_nxt = wdata[19:0];
			end else if (addr == `SCD_A_NUMS) begin
				nums_nxt = wdata;
			end else if (addr == `SCD_A_ALLOW) begin
				alw_nxt = wdata;
			end
		end
		if (rd) begin
			if (addr == `SCD_A_CTRL) begin
				rdata_nxt = {20'h0, nalw_r, nnum_r, 2'h0, cfg_r};
			end else if (addr == `SCD_A_RETRY) begin
				rdata_nxt = {28'h0, retry_r};
			end else if (addr == `SCD_A_WAIT) begin
				rdata_nxt = {12'h0, wait_r};
			end else if (addr == `SCD_A_DELAY) begin
				rdata_nxt = {12'h0, dly_r};
			end else if (addr == `SCD_A_MIND) begin
				rdata_nxt = {12'h0, mind_r};
			end else if (addr == `SCD_A_INACT) begin
				rdata_nxt = {12'h0, inact_r};
			end else if (addr == `SCD_A_NUMS) begin
				rdata_nxt = nums_r;
			end else if (addr == `SCD_A_ALLOW) begin
				rdata_nxt = alw_r;
			end else if (addr == `SCD_A_STAT) begin
				rdata_nxt = {18'h0, gup_r, cfg_err, dtr, p.dsr, p.cts, tries_r,
					nidx_r, st_r};
			end
		end
	end
	// ****************************************
	// Connection state machine
	// ****************************************
	// Refused setups keep the port idle rather than half working
	assign cfg_err = (cfg_r.v25 & cfg_r.x21) // RULE16
		| (cfg_r.pool & ~(cfg_r.v25 & cfg_r.pend)); // RULE17
	assign tick = (pre_r == 16'(TICK_CYC - 1));
	logic start, inc_ok, inc_in, rx_cfi, hold_ok;
	assign start = cfg_r.en & ~cfg_err & ~gup_r & (~cfg_r.pend | pkt_pend); // RULE2 RULE3
	assign inc_in = rvld & (rsh_r[15:8] == `SCD_C_INC);
	// No caller number means screening cannot pass the call
	assign inc_ok = ~cfg_r.screen | ((rsh_r[7:0] != 8'h0)
		& listed(rsh_r[7:0], alw_r, nalw_r)); // RULE18
	assign rx_cfi = rvld & (rsh_r[15:8] == `SCD_C_CFI);
	// One spare bit so a saturated age cannot wrap past the guard
	assign hold_ok = ({1'b0, age_r} + 21'(`SCD_GUARD_MS) >= {1'b0, mind_r}); // RULE8
	always_comb begin
		st_nxt = st_r;
		tries_nxt = tries_r;
		nidx_nxt = nidx_r;
		gup_nxt = gup_r;
		tx_go = 1'b0;
		if (wr && addr == `SCD_A_CTRL) begin
			gup_nxt = 1'b0;
		end
		case (st_r)
			S_IDLE: begin
				if (start) begin
					st_nxt = S_CALL;
				end else if (cfg_r.en && cfg_r.v25 && !cfg_err && inc_in) begin
					st_nxt = inc_ok ? S_ANS : S_DROP; // RULE14 RULE4
				end
			end
			S_CALL: begin
				if (!cfg_r.v25) begin
					st_nxt = S_WAIT; // RULE1
				end else if (p.cts) begin
					st_nxt = S_SEND;
					tx_go = 1'b1; // RULE10
				end else if (tick && tmr_r >= wait_r) begin
					st_nxt = S_FAIL;
				end
			end
			S_SEND: begin
				if (tcnt_r == 5'h0 && !tx_go) begin
					st_nxt = S_WAIT;
				end
			end
			S_WAIT: begin
				if (p.dsr) begin
					st_nxt = S_UP; // RULE15
				end else if (rx_cfi || (tick && tmr_r >= wait_r)) begin
					st_nxt = S_FAIL; // RULE6
				end
			end
			S_ANS: begin
				if (p.dsr) begin
					st_nxt = S_UP; // RULE15
				end else if (tick && tmr_r >= wait_r) begin
					st_nxt = S_DROP;
				end
			end
			S_UP: begin
				tries_nxt = 4'h0;
				if (!p.dsr || !cfg_r.en || cfg_err) begin
					st_nxt = S_DROP;
				end else if (cfg_r.pend && idle_r >= inact_r && hold_ok) begin
					st_nxt = S_DROP; // RULE7 RULE5
				end
			end
			S_FAIL: begin
				if (tick && tmr_r >= dly_r) begin
					if (tries_r >= retry_r) begin
						st_nxt = S_IDLE;
						gup_nxt = 1'b1; // RULE21
					end else begin
						st_nxt = S_CALL;
						tries_nxt = tries_r + 4'h1;
						nidx_nxt = (nidx_r >= nnum_r) ? 2'h0 : nidx_r + 2'h1; // RULE19
					end
				end
			end
			default: begin
				// A reject dip lasts at least one full tick so the adapter can see it
				if (tick && tmr_r != 20'h0) begin
					st_nxt = S_IDLE;
				end
			end
		endcase
	end
	// DTR drops in fail and drop states; a V.25 bis port keeps it up to hear calls
	always_comb begin
		dtr = 1'b0;
		if (st_r == S_CALL || st_r == S_SEND || st_r == S_WAIT || st_r == S_UP
			|| st_r == S_ANS) begin
			dtr = 1'b1; // RULE1
		end else if (st_r == S_IDLE) begin
			dtr = cfg_r.v25 & cfg_r.en & ~cfg_err;
		end
	end
	always_comb begin
		pre_nxt = tick ? 16'h0 : pre_r + 16'h1;
		tmr_nxt = (st_nxt != st_r) ? 20'h0 : (tick ? tmr_r + 20'h1 : tmr_r);
		age_nxt = (st_r != S_UP) ? 20'h0 : ((tick && age_r != 20'hfffff) ? age_r + 20'h1 : age_r);
		idle_nxt = (st_r != S_UP || tx_act || rx_act) ? 20'h0 // RULE7
			: ((tick && idle_r != 20'hfffff) ? idle_r + 20'h1 : idle_r);
	end
	// ****************************************
	// Dialog link: start bit then code and number, MSB first
	// ****************************************
	always_comb begin
		tsh_nxt = tsh_r;
		tcnt_nxt = tcnt_r;
		if (tx_go) begin
			tsh_nxt = {1'b0, `SCD_C_CRN, nums_r[nidx_r*8 +: 8]}; // RULE10
			tcnt_nxt = 5'h11;
		end else if (sc_fall && tcnt_r != 5'h0) begin
			tsh_nxt = {tsh_r[15:0], 1'b1};
			tcnt_nxt = tcnt_r - 5'h1;
		end
		rsh_nxt = rsh_r;
		rcnt_nxt = rcnt_r;
		if (sc_rise) begin
			if (rcnt_r == 5'h0) begin
				rcnt_nxt = p.rxd ? 5'h0 : 5'h10;
			end else begin
				rsh_nxt = {rsh_r[14:0], p.rxd};
				rcnt_nxt = rcnt_r - 5'h1;
			end
		end
	end
	logic rdone_r;
	always_ff @(posedge clk or negedge rsn) begin
		if (!rsn) begin
			cfg_r <= '0;
			retry_r <= `SCD_R_RETRY;
			wait_r <= `SCD_R_WAIT;
			dly_r <= `SCD_R_DELAY;
			mind_r <= `SCD_R_MIND;
			inact_r <= `SCD_R_INACT;
			nums_r <= 32'h0;
			alw_r <= 32'h0;
			nnum_r <= 2'h0;
			nalw_r <= 2'h0;
			rdata <= 32'h0;
			st_r <= S_IDLE;
			tries_r <= 4'h0;
			nidx_r <= 2'h0;
			gup_r <= 1'b0;
			pre_r <= 16'h0;
			tmr_r <= 20'h0;
			age_r <= 20'h0;
			idle_r <= 20'h0;
			tsh_r <= 17'h1ffff;
			tcnt_r <= 5'h0;
			rsh_r <= 16'h0;
			rcnt_r <= 5'h0;
			rdone_r <= 1'b0;
			txd <= 1'b1;
		end else begin
			cfg_r <= cfg_nxt;
			retry_r <= retry_nxt;
			wait_r <= wait_nxt;
			dly_r <= dly_nxt;
			mind_r <= mind_nxt;
			inact_r <= inact_nxt;
			nums_r <= nums_nxt;
			alw_r <= alw_nxt;
			nnum_r <= nnum_nxt;
			nalw_r <= nalw_nxt;
			rdata <= rdata_nxt;
			st_r <= st_nxt;
			tries_r <= tries_nxt;
			nidx_r <= nidx_nxt;
			gup_r <= gup_nxt;
			pre_r <= pre_nxt;
			tmr_r <= tmr_nxt;
			age_r <= age_nxt;
			idle_r <= idle_nxt;
			tsh_r <= tsh_nxt;
			tcnt_r <= tcnt_nxt;
			rsh_r <= rsh_nxt;
			rcnt_r <= rcnt_nxt;
			rdone_r <= sc_rise & (rcnt_r == 5'h1);
			txd <= (tcnt_nxt != 5'h0) ? tsh_nxt[16] : 1'b1;
		end
	end
	assign rvld = rdone_r;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rsn);
	property p_man_dtr;
		st_r == S_IDLE && !cfg_r.v25 |-> !dtr;
	endproperty
	a_man_dtr: assert property (p_man_dtr) else $error("manual idle DTR"); // RULE1
	property p_pend_start;
		st_r == S_IDLE && st_nxt == S_CALL && cfg_r.pend |-> pkt_pend;
	endproperty
	a_pend_start: assert property (p_pend_start) else $error("call without data"); // RULE2
	property p_no_ans;
		st_r == S_IDLE && !cfg_r.v25 |=> st_r != S_ANS;
	endproperty
	a_no_ans: assert property (p_no_ans) else $error("manual port answered"); // RULE4
	property p_hold;
		st_r == S_UP && !cfg_r.pend && cfg_r.en && !cfg_err && p.dsr |=> st_r == S_UP;
	endproperty
	a_hold: assert property (p_hold) else $error("enable mode dropped"); // RULE5
	property p_guard;
		st_r == S_UP && st_nxt == S_DROP && p.dsr && cfg_r.en && !cfg_err
			|-> idle_r >= inact_r && {1'b0, age_r} + 21'(`SCD_GUARD_MS) >= {1'b0, mind_r};
	endproperty
	a_guard: assert property (p_guard) else $error("dropped too early"); // RULE8
	property p_crn;
		st_r == S_CALL && st_nxt == S_SEND |=> ##1 !txd;
	endproperty
	a_crn: assert property (p_crn) else $error("no request sent"); // RULE10
	property p_rej;
		st_r == S_IDLE && !start && dtr && inc_in && !inc_ok |=> !dtr ##1 !dtr;
	endproperty
	a_rej: assert property (p_rej) else $error("call not rejected"); // RULE14
	property p_dsr;
		st_r != S_UP && st_nxt == S_UP |-> p.dsr;
	endproperty
	a_dsr: assert property (p_dsr) else $error("up without DSR"); // RULE15
	property p_x21;
		cfg_r.v25 && cfg_r.x21 && st_r == S_IDLE |=> st_r == S_IDLE;
	endproperty
	a_x21: assert property (p_x21) else $error("dial on X.21"); // RULE16
	property p_next;
		st_r == S_FAIL && st_nxt == S_CALL |=> nidx_r != $past(nidx_r) || nnum_r == 2'h0;
	endproperty
	a_next: assert property (p_next) else $error("same number redialed"); // RULE19
	property p_gup;
		st_r == S_FAIL && tick && tmr_r >= dly_r && tries_r >= retry_r |=> gup_r;
	endproperty
	a_gup: assert property (p_gup) else $error("no give up"); // RULE21
	c_up: cover property (st_r == S_WAIT ##1 st_r == S_UP);
	c_ans: cover property (st_r == S_IDLE ##1 st_r == S_ANS);
	c_retry: cover property (st_r == S_FAIL ##1 st_r == S_CALL);
endmodule

// *** dv/scd_adapter.sv ***
// Behavioural terminal adapter on the far side of the dial control block
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_adapter
	import scd_pkg::*;
(
	// Leads from the router
	input wire logic dtr,
	input wire logic txd,
	// Leads to the router
	output scd_lnk_t lnk
);
	logic run = 1'b0;

	initial lnk = '{rxd: 1'b1, dsr: 1'b0, cts: 1'b0, sclk: 1'b0};
	// Link clock stands still outside dialogs and frames; offset keeps it off clk edges
	initial begin
		#7;
		forever #80 if (run || lnk.sclk) lnk.sclk = ~lnk.sclk;
	end
	// Path is torn down as soon as the router drops its lead
	always @(negedge dtr) lnk.dsr = 1'b0;

	// ****************************************
	// Link actions
	// ****************************************
	task automatic up;
		#3 lnk.dsr = 1'b1;
	endtask

	// Start bit, then code and number MSB first; data set on sclk fall
	task automatic send(input logic [15:0] fr);
		logic [18:0] bits;
		bits = {2'b11, 1'b0, fr};
		run = 1'b1;
		for (int i = 18; i >= 0; i--) begin
			@(negedge lnk.sclk);
			lnk.rxd = bits[i];
		end
		@(negedge lnk.sclk);
		lnk.rxd = 1'b1;
		@(negedge lnk.sclk);
		run = lnk.cts;
	endtask

	// Sampled on the fall because the router moves its bit a few clocks after it
	task automatic dial(output logic [15:0] fr);
		int n;
		n = 0;
		lnk.cts = 1'b1;
		run = 1'b1;
		do begin
			@(negedge lnk.sclk);
			n++;
		end while (txd !== 1'b0 && n < 64);
		for (int i = 15; i >= 0; i--) begin
			@(negedge lnk.sclk);
			fr[i] = txd;
		end
		if (fr[15:8] == `SCD_C_CRN) send({`SCD_C_VAL, 8'h00});
		lnk.cts = 1'b0;
		run = 1'b0;
	endtask
endmodule

// *** dv/scd_dial_bench.sv ***
// Self-checking bench for the dial control block
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_dial_bench
	import scd_pkg::*;
;
	localparam int TK = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic pkt_pend = 1'b0;
	logic tx_act = 1'b0;
	logic rx_act = 1'b0;
	scd_lnk_t lnk;
	logic dtr;
	logic txd;
	logic fell = 1'b0;
	logic [15:0] f;
	logic [7:0] cid [3] = '{8'h3c, 8'h77, 8'h00};
	int failures = 0;
	int compares = 0;

	always #10 clk = ~clk;
	// A reject shows only as a short dip of the lead, so latch it
	always @(negedge dtr) fell = 1'b1;

	scd_dial #(.TICK_CYC(TK), .POOL_PORTS(3), .POOL_NETS(16)) u_dut (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pkt_pend(pkt_pend), .tx_act(tx_act), .rx_act(rx_act),
		.lnk(lnk), .dtr(dtr), .txd(txd));
	scd_adapter u_adp (.dtr(dtr), .txd(txd), .lnk(lnk));

	// ****************************************
	// Access and checking tasks
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic ms(input int n);
		cyc(n * TK);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		cyc(1);
	endtask

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		// Read data stand for this one cycle only; look mid-cycle
		@(negedge clk);
		chk(rdata & m, e);
		@(posedge clk);
	endtask

	task automatic cfg(input logic [31:0] c);
		wreg(`SCD_A_CTRL, c);
		cyc(4);
	endtask

	task automatic act;
		tx_act <= 1'b1;
		cyc(1);
		tx_act <= 1'b0;
		ms(2);
		rx_act <= 1'b1;
		cyc(1);
		rx_act <= 1'b0;
		ms(2);
	endtask

	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		cyc(16);
		rstn <= 1'b1;
		cyc(4);
		chk(dtr, 1'b0);
		rdm(`SCD_A_RETRY, '1, `SCD_R_RETRY);
		rdm(`SCD_A_WAIT, '1, `SCD_R_WAIT);
		rdm(`SCD_A_DELAY, '1, `SCD_R_DELAY);
		rdm(`SCD_A_MIND, '1, `SCD_R_MIND);
		rdm(`SCD_A_INACT, '1, `SCD_R_INACT);
		rdm(8'h24, '1, 32'h0);
		wreg(`SCD_A_RETRY, 32'h1);
		wreg(`SCD_A_WAIT, 32'h4);
		wreg(`SCD_A_DELAY, 32'h4);
		wreg(`SCD_A_MIND, 32'h406);
		wreg(`SCD_A_INACT, 32'h5);
		rdm(`SCD_A_WAIT, '1, 32'h4);
		cfg(32'h0d);
		rdm(`SCD_A_STAT, 32'h1807, 32'h1000);
		cfg(32'h11);
		rdm(`SCD_A_STAT, 32'h1807, 32'h1000);
		cfg(32'h17);
		rdm(`SCD_A_STAT, 32'h1000, 32'h0);
		cfg(32'h0);
		ms(2);
		wreg(`SCD_A_NUMS, 32'h44332211);
		// The dialog plus the adapter's answer outlast a four tick wait
		wreg(`SCD_A_WAIT, 32'h40);
		cfg(32'h105);
		chk(dtr, 1'b1);
		u_adp.dial(f);
		chk(f, {`SCD_C_CRN, 8'h11});
		cyc(8);
		rdm(`SCD_A_STAT, 32'h7, 32'h2);
		u_adp.up();
		cyc(8);
		rdm(`SCD_A_STAT, 32'h7, 32'h6);
		cfg(32'h0);
		ms(2);
		cfg(32'h5);
		u_adp.dial(f);
		chk(f, {`SCD_C_CRN, 8'h11});
		u_adp.send({`SCD_C_CFI, 8'h00});
		cyc(2);
		rdm(`SCD_A_STAT, 32'h7, 32'h7);
		wreg(`SCD_A_WAIT, 32'h4);
		ms(18);
		rdm(`SCD_A_STAT, 32'h2007, 32'h2000);
		cfg(32'h1);
		chk(dtr, 1'b1);
		u_adp.up();
		cyc(8);
		rdm(`SCD_A_STAT, 32'h7, 32'h6);
		ms(45);
		chk(dtr, 1'b1);
		cfg(32'h0);
		chk(dtr, 1'b0);
		ms(2);
		cfg(32'h3);
		ms(2);
		chk(dtr, 1'b0);
		u_adp.send({`SCD_C_INC, 8'h2d});
		cyc(8);
		chk(dtr, 1'b0);
		pkt_pend <= 1'b1;
		cyc(8);
		chk(dtr, 1'b1);
		u_adp.up();
		cyc(8);
		pkt_pend <= 1'b0;
		ms(12);
		chk(dtr, 1'b1);
		repeat (10) act();
		chk(dtr, 1'b1);
		ms(1);
		chk(dtr, 1'b1);
		ms(6);
		chk(dtr, 1'b0);
		cfg(32'h0);
		ms(2);
		wreg(`SCD_A_ALLOW, 32'h5a4b3c2d);
		for (int i = 0; i < 3; i++) begin
			cfg(32'hc27);
			fell = 1'b0;
			u_adp.send({`SCD_C_INC, cid[i]});
			cyc(6);
			chk(fell, i > 0);
			if (i == 0) rdm(`SCD_A_STAT, 32'h7, 32'h4);
			cfg(32'h0);
			ms(8);
		end
		cfg(32'h101);
		ms(6);
		rdm(`SCD_A_STAT, 32'h7, 32'h7);
		ms(4);
		rdm(`SCD_A_STAT, 32'h1f8, 32'h28);
		ms(10);
		rdm(`SCD_A_STAT, 32'h2007, 32'h2000);
		test_done();
	end

	// Whole run needs a few thousand cycles; this bound only catches a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done();
	end
endmodule
